//--- hw/agent_health.sv
`timescale 1ns/1ps
module agent_health #(
	parameter int WINDOW = 3
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic done,
	input  wire logic ok,
	output logic      alert
);
	logic [WINDOW-1:0] hist_r;

	// a bad or missing answer in the last few transactions raises the flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hist_r <= '0;
			alert  <= 1'b0;
		end else if (done) begin
			hist_r <= {hist_r[WINDOW-2:0], ~ok};
			alert  <= (|hist_r[WINDOW-2:0]) | ~ok;
		end
	end
endmodule

//--- hw/bit_rate_divider.sv
`timescale 1ns/1ps
module bit_rate_divider #(
	parameter int BASE_CYC = 13
) (
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	input  wire logic                        run,
	input  wire thermal_regs_pkg::speed_t    speed,
	output logic                             bit_tick
);
	import thermal_regs_pkg::*;

	logic [7:0] cnt_r;
	logic [7:0] limit;

	// each slower setting halves the rate
	assign limit = 8'((BASE_CYC << speed) - 1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r    <= 8'h00;
			bit_tick <= 1'b0;
		end else if (!run || cnt_r >= limit) begin
			cnt_r    <= 8'h00;
			bit_tick <= run;
		end else begin
			cnt_r    <= cnt_r + 8'h01;
			bit_tick <= 1'b0;
		end
	end
endmodule

//--- hw/thermal_link_regs.sv
`timescale 1ns/1ps
module thermal_link_regs
	import thermal_regs_pkg::*;
#(
	parameter int AGENTS = NUM_AGENTS
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic [31:0]       hrdata,
	output logic              hreadyout,
	output logic              hresp,
	output logic              irq,
	output logic              txn_start,
	output logic [7:0]        target_addr,
	output logic              bit_tick,
	input  wire logic         txn_done,
	input  wire logic         txn_ok,
	input  wire logic [15:0]  txn_temp
);
	import thermal_regs_pkg::*;

	logic [7:0]            ctl_r;
	logic [7:0]            sensor_addr_r;
	logic [15:0]           temp_r;
	logic [AGENTS-1:0]     alert;
	logic [2:0]            irq_stat_r;
	logic [2:0]            irq_mask_r;
	logic [1:0]            link_ctrl_r;
	logic [1:0]            agent_r;
	txn_state_t            state_r;
	logic                  wr_pend_r;
	logic [7:0]            widx_r;
	logic                  tick;
	logic [AGENTS-1:0]     agent_done;
	// sequencer next state, worked out combinationally so the flops stay simple
	txn_state_t            state_nxt;
	logic [1:0]            agent_nxt;
	logic                  start_nxt;
	logic [7:0]            target_nxt;
	logic                  load_temp;

	// one compare per register, shared by the read and write decoders
	function automatic logic idx_hit(
		input logic [7:0] idx,
		input logic [7:0] reg_idx
	);
		return idx == reg_idx;
	endfunction

	// agents are polled in turn and the count wraps after the last one
	function automatic logic [1:0] next_agent(
		input logic [1:0] cur
	);
		return 2'((32'(cur) + 1) % AGENTS);
	endfunction

	// the speed field feeds both the divider and the read path
	function automatic speed_t speed_of(
		input logic [7:0] ctl
	);
		return speed_t'(ctl[SPEED_LSB+:2]);
	endfunction

	// unmapped indices read zero; every register sits in bits 7..0
	// all sources are arguments so a continuous assignment sees every change
	function automatic logic [31:0] read_word(
		input logic [7:0]  idx,
		input logic [7:0]  flags,
		input logic [7:0]  sensor,
		input logic [15:0] temp,
		input logic [2:0]  stat,
		input logic [2:0]  mask,
		input logic [1:0]  link
	);
		logic [31:0] word;
		word = 32'h0000_0000;
		if (idx_hit(idx, IDX_WARN_SPEED)) begin
			word = {24'h00_0000, flags};
		end else if (idx_hit(idx, IDX_SENSOR_ADDR)) begin
			word = {24'h00_0000, sensor};
		end else if (idx_hit(idx, IDX_TEMP_HIGH)) begin
			word = {24'h00_0000, temp[15:8]};
		end else if (idx_hit(idx, IDX_TEMP_LOW)) begin
			word = {24'h00_0000, temp[7:0]};
		end else if (idx_hit(idx, IDX_IRQ_STATUS)) begin
			word = {29'h0000_0000, stat};
		end else if (idx_hit(idx, IDX_IRQ_MASK)) begin
			word = {29'h0000_0000, mask};
		end else if (idx_hit(idx, IDX_LINK_CTRL)) begin
			word = {30'h0000_0000, link};
		end
		return word;
	endfunction

	// link control: an external host owns the link when select is set
	wire         host_source_select = link_ctrl_r[1];
	wire         poll_en            = link_ctrl_r[0];
	wire         link_run           = poll_en & ~host_source_select;

	// bus decode; a write lands one cycle after its address phase
	wire         addr_phase         = hsel & hready & htrans[1];
	wire [7:0]   aidx               = haddr[9:2];
	wire [7:0]   wbyte              = hwdata[7:0];
	wire         wr_ctl             = wr_pend_r && idx_hit(widx_r, IDX_WARN_SPEED);
	wire         wr_sens            = wr_pend_r && idx_hit(widx_r, IDX_SENSOR_ADDR);
	wire         wr_stat            = wr_pend_r && idx_hit(widx_r, IDX_IRQ_STATUS);
	wire         wr_mask            = wr_pend_r && idx_hit(widx_r, IDX_IRQ_MASK);
	wire         wr_link            = wr_pend_r && idx_hit(widx_r, IDX_LINK_CTRL);

	// status events; a done that arrives outside the wait state is ignored
	wire         cur_done           = state_r == ST_WAIT && txn_done;
	wire [7:0]   flags_byte         = {alert, 2'b00, speed_of(ctl_r)};
	wire [2:0]   irq_event          = {|alert, cur_done & ~txn_ok, cur_done};
	wire [2:0]   irq_stat_nxt       = (irq_stat_r & ~(wr_stat ? wbyte[2:0] : 3'b000)) | irq_event;

	wire [31:0]  rd_mux;
	assign rd_mux = read_word(aidx, flags_byte, sensor_addr_r, temp_r, irq_stat_r, irq_mask_r, link_ctrl_r);

	bit_rate_divider #(
		.BASE_CYC (FAST_BIT_CYC)
	) u_div (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.run      (link_run),
		.speed    (speed_of(ctl_r)),
		.bit_tick (tick)
	);

	// one health tracker per agent, each fed only by answers addressed to it
	genvar g;
	generate
		for (g = 0; g < AGENTS; g++) begin : g_agent
			assign agent_done[g] = cur_done && agent_r == 2'(g);
			agent_health #(
				.WINDOW (FAIL_WINDOW)
			) u_health (
				.hclk    (hclk),
				.hresetn (hresetn),
				.done    (agent_done[g]),
				.ok      (txn_ok),
				.alert   (alert[g])
			);
		end
	endgenerate

	// bus slave: zero-wait, writes land one cycle after address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			widx_r    <= 8'h00;
		end else begin
			wr_pend_r <= addr_phase & hwrite;
			widx_r    <= aidx;
		end
	end

	// read data is captured in the address phase and held until the next read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			hrdata <= rd_mux;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// flag bits in this register are hardware owned; only speed is writable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_r <= RST_WARN_SPEED;
		end else if (wr_ctl) begin
			ctl_r <= {6'h00, wbyte[SPEED_LSB+:2]};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sensor_addr_r <= RST_SENSOR_ADDR;
		end else if (wr_sens) begin
			sensor_addr_r <= wbyte;
		end
	end

	// mask and link control come up cleared so nothing polls until software asks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask_r <= 3'b000;
		end else if (wr_mask) begin
			irq_mask_r <= wbyte[2:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link_ctrl_r <= 2'b00;
		end else if (wr_link) begin
			link_ctrl_r <= wbyte[1:0];
		end
	end

	// set wins over write-one-to-clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_r <= 3'b000;
		end else begin
			irq_stat_r <= irq_stat_nxt;
		end
	end

	// built from the next status so the line is never a cycle behind the bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_nxt & irq_mask_r);
		end
	end

	// polling sequencer: one agent at a time, round robin
	always_comb begin
		state_nxt  = state_r;
		agent_nxt  = agent_r;
		start_nxt  = 1'b0;
		target_nxt = target_addr;
		load_temp  = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (link_run) begin
					start_nxt  = 1'b1;
					target_nxt = AGENT_BASE_ADDR + {6'h00, agent_r};
					state_nxt  = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// no timeout here: a silent far side must still raise done
				if (txn_done) begin
					load_temp = txn_ok;
					state_nxt = ST_DONE;
				end
			end
			default: begin
				agent_nxt = next_agent(agent_r);
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// link outputs leave flip-flops directly
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r     <= ST_IDLE;
			agent_r     <= 2'b00;
			txn_start   <= 1'b0;
			target_addr <= AGENT_BASE_ADDR;
			bit_tick    <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			agent_r     <= agent_nxt;
			txn_start   <= start_nxt;
			target_addr <= target_nxt;
			bit_tick    <= tick;
		end
	end

	// both bytes load from one good answer so temp_r never holds halves of two answers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			temp_r <= RST_TEMP;
		end else if (load_temp) begin
			temp_r <= txn_temp;
		end
	end
endmodule

//--- include/thermal_regs_pkg.sv
package thermal_regs_pkg;

	// register offsets (not all multiples of four, so byte address = 4 * index)
	localparam logic [7:0]  IDX_WARN_SPEED   = 8'hE8;
	localparam logic [7:0]  IDX_SENSOR_ADDR  = 8'hF1;
	localparam logic [7:0]  IDX_TEMP_HIGH    = 8'hFE;
	localparam logic [7:0]  IDX_TEMP_LOW     = 8'hFF;
	localparam logic [7:0]  IDX_IRQ_STATUS   = 8'hC0;
	localparam logic [7:0]  IDX_IRQ_MASK     = 8'hC1;
	localparam logic [7:0]  IDX_LINK_CTRL    = 8'hC2;

	// reset values
	localparam logic [7:0]  RST_WARN_SPEED   = 8'h00;
	localparam logic [7:0]  RST_SENSOR_ADDR  = 8'h48;
	localparam logic [7:0]  RST_TEMP         = 8'h00;

	// field positions and agent count
	localparam int          FLAG_LSB         = 4;
	localparam int          NUM_AGENTS       = 4;
	localparam int          SPEED_LSB        = 0;

	// agent link addresses
	localparam logic [7:0]  AGENT_BASE_ADDR  = 8'h30;

	// absent/alert window
	localparam int          FAIL_WINDOW      = 3;

	// bit timing: fastest rate 1.5 MHz from 20 MHz clock
	localparam int          CLK_HZ           = 20000000;
	localparam int          FAST_BIT_HZ      = 1500000;
	localparam int          FAST_BIT_CYC     = CLK_HZ / FAST_BIT_HZ;

	// interrupt status bits
	localparam int          IRQ_DONE         = 0;
	localparam int          IRQ_FAIL         = 1;
	localparam int          IRQ_ALERT        = 2;

	typedef enum logic [1:0] {
		SPD_1500K,
		SPD_750K,
		SPD_375K,
		SPD_187K5
	} speed_t;

	typedef enum {
		ST_IDLE,
		ST_WAIT,
		ST_DONE
	} txn_state_t;

endpackage

//--- verif/agent_model.sv
`timescale 1ns/1ps
module agent_model #(
	parameter logic [15:0] TEMP = 16'h0100
) (
	input  wire logic        hclk,
	input  wire logic        txn_start,
	input  wire logic [7:0]  target_addr,
	input  wire logic [3:0]  absent,
	input  wire logic [3:0]  lag,
	output logic             txn_done,
	output logic             txn_ok,
	output logic [15:0]      txn_temp
);
	logic [1:0] who;
	initial begin
		txn_done = 1'b0;
		txn_ok = 1'b0;
		txn_temp = ~TEMP;
		forever begin
			@(posedge hclk);
			if (txn_start === 1'b1) begin
				who = target_addr[1:0];
				repeat (lag) @(posedge hclk);
				txn_done <= 1'b1;
				txn_ok <= ~absent[who];
				// a failed answer carries junk so a wrong load shows up
				txn_temp <= absent[who] ? ~TEMP : TEMP;
				@(posedge hclk);
				txn_done <= 1'b0;
				txn_ok <= absent[who];
				txn_temp <= ~TEMP;
			end
		end
	end
endmodule

//--- verif/thermal_link_properties.sv
`timescale 1ns/1ps
module thermal_link_props (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic [31:0] hrdata,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	input  wire logic        txn_start,
	input  wire logic [7:0]  target_addr,
	input  wire logic        bit_tick
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// the sequencer needs a done and two more cycles before the next start
	sequence s_quiet2;
		!txn_start ##1 !txn_start;
	endsequence
	AST_READY: assert property (hreadyout)
		else $error("wait state inserted");
	AST_OKAY: assert property (!hresp)
		else $error("error response");
	AST_BYTE: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_RANGE: assert property (target_addr >= 8'h30 && target_addr <= 8'h33)
		else $error("target out of range");
	AST_MOVE: assert property ($changed(target_addr) |-> txn_start)
		else $error("target moved without start");
	AST_NEXT: assert property ($changed(target_addr) |-> target_addr ==
		(($past(target_addr) == 8'h33) ? 8'h30 : $past(target_addr) + 8'h01))
		else $error("agent order broken");
	AST_GAP: assert property (txn_start |=> s_quiet2)
		else $error("starts too close");
	AST_TICK: assert property (bit_tick |=> !bit_tick [*8])
		else $error("bit tick too fast");
endmodule
bind thermal_link_regs thermal_link_props u_chk (.hclk(hclk), .hresetn(hresetn), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .txn_start(txn_start), .target_addr(target_addr), .bit_tick(bit_tick));

//--- verif/thermal_link_regs_test.sv
`timescale 1ns/1ps
module thermal_link_regs_test;
	import thermal_regs_pkg::*;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, irq, txn_start, bit_tick, txn_done, txn_ok;
	logic [7:0]  target_addr;
	logic [15:0] txn_temp;
	logic [3:0]  absent = 4'h4, lag = 4'h1;
	int          n_errors = 0, checks = 0, n_start = 0, goal = 0, gap = 0;
	wire         hready = hreadyout;
	always #25 hclk = ~hclk;
	always @(posedge hclk) if (txn_start === 1'b1) n_start++;
	thermal_link_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .irq(irq), .txn_start(txn_start), .target_addr(target_addr), .bit_tick(bit_tick),
		.txn_done(txn_done), .txn_ok(txn_ok), .txn_temp(txn_temp));
	agent_model #(.TEMP(16'hFF9C)) u_agent (.hclk(hclk), .txn_start(txn_start), .target_addr(target_addr),
		.absent(absent), .lag(lag), .txn_done(txn_done), .txn_ok(txn_ok), .txn_temp(txn_temp));
	task automatic stop_test;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// kind 0 ready, 1 bit tick, 2 start count; gap keeps the edges waited
	task automatic wait_on(input int k, input int lim);
		for (int i = 1; i <= lim; i++) begin
			@(posedge hclk);
			gap = i;
			if (k == 0 ? hreadyout === 1'b1 : k == 1 ? bit_tick === 1'b1 : n_start >= goal)
				return;
		end
		n_errors++;
		stop_test();
	endtask
	task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
		htrans <= 2'b10;
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		hwrite <= wr;
		wait_on(0, 20);
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		wait_on(0, 20);
		r = hrdata;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string nm);
		bus(idx, 1'b0, 8'h00);
		check(nm, r, exp);
	endtask
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(IDX_WARN_SPEED, 32'h0, "warn");
		rd(IDX_SENSOR_ADDR, 32'h48, "sensor");
		rd(IDX_TEMP_HIGH, 32'h0, "high");
		rd(IDX_TEMP_LOW, 32'h0, "low");
		bus(IDX_SENSOR_ADDR, 1'b1, 8'hA5);
		bus(IDX_TEMP_HIGH, 1'b1, 8'h5A);
		bus(IDX_TEMP_LOW, 1'b1, 8'h5A);
		bus(8'h10, 1'b1, 8'hFF);
		bus(IDX_WARN_SPEED, 1'b1, 8'hFC);
		rd(IDX_SENSOR_ADDR, 32'hA5, "sensor");
		rd(IDX_TEMP_HIGH, 32'h0, "high");
		rd(IDX_TEMP_LOW, 32'h0, "low");
		rd(8'h10, 32'h0, "hole");
		rd(IDX_WARN_SPEED, 32'h0, "warn");
		bus(IDX_IRQ_MASK, 1'b1, 8'h00);
		bus(IDX_LINK_CTRL, 1'b1, 8'h03);
		repeat (60) @(posedge hclk);
		check("starts", n_start, 0);
		bus(IDX_LINK_CTRL, 1'b1, 8'h01);
		goal = 8;
		wait_on(2, 2000);
		lag <= 4'h9;
		goal = 16;
		wait_on(2, 2000);
		rd(IDX_WARN_SPEED, 32'h40, "warn");
		rd(IDX_TEMP_HIGH, 32'hFF, "high");
		rd(IDX_TEMP_LOW, 32'h9C, "low");
		rd(IDX_IRQ_STATUS, 32'h7, "status");
		check("irq", {31'h0, irq}, 32'h0);
		bus(IDX_IRQ_MASK, 1'b1, 8'h02);
		rd(IDX_IRQ_MASK, 32'h2, "mask");
		check("irq", {31'h0, irq}, 32'h1);
		absent <= 4'h0;
		goal = 32;
		wait_on(2, 3000);
		rd(IDX_WARN_SPEED, 32'h0, "warn");
		for (int s = 0; s < 4; s++) begin
			bus(IDX_WARN_SPEED, 1'b1, 8'(s));
			rd(IDX_WARN_SPEED, 32'(s), "speed");
			wait_on(1, 200);
			wait_on(1, 200);
			wait_on(1, 200);
			check("period", gap, FAST_BIT_CYC << s);
		end
		bus(IDX_LINK_CTRL, 1'b1, 8'h00);
		repeat (30) @(posedge hclk);
		bus(IDX_IRQ_STATUS, 1'b1, 8'h07);
		rd(IDX_IRQ_STATUS, 32'h0, "status");
		check("irq", {31'h0, irq}, 32'h0);
		stop_test();
	end
endmodule
